// [verilog/cfgpm_top.sv]
// Configuration-space register bank: index/data port, pin function
// select, base-address decode and interrupt/DMA request gating.
// Assumes host I/O cycles arrive as one-cycle requests on clk_i.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - alt select reachable only in config state
// - alt select read/write, clears to zero
// - four 2-bit fields pick GPIO or UART2
// - reserved registers hold fixed power-up values
// - serial ports decode 0x100-0x3F8, 8-aligned
// - infrared block decodes 0x100-0x7F8, 8-aligned
// - strap picks 0x2E or 0x4E at power-up
// - block disable bits gate IRQ and DMA
// - aux output two low blocks port IRQ
// - UART2 DMA enable gates its DMA request
// - neighbour groups share same field encoding
module cfgpm_top (
   input  wire logic            clk_i,
   input  wire logic            srst_i,
   input  wire logic            cfg_state_i,
   input  wire logic            config_port_strap_i,
   input  wire logic            io_req_i,
   input  wire logic            io_write_i,
   input  wire logic [15:0]     io_addr_i,
   input  wire logic [7:0]      io_wdata_i,
   output logic                 io_claim_o,
   output logic      [7:0]      io_rdata_o,
   output logic      [4:0]      dev_cs_o,
   output logic      [2:0]      dev_offset_o,
   output logic                 dev_write_o,
   output logic      [7:0]      dev_wdata_o,
   output logic      [7:0]      runtime_base_o,
   input  wire logic [4:0]      ldev_active_i,
   input  wire logic [3:0]      uart_irq_raw_i,
   input  wire logic [3:0][7:0] uart_modem_control_reg_i,
   input  wire logic            uart2_dma_req_i,
   input  wire logic            uart2_dma_en_i,
   input  wire logic            ir_irq_raw_i,
   input  wire logic            ir_irq_en_i,
   input  wire logic            ir_dma_req_i,
   input  wire logic            ir_dma_en_i,
   output logic      [3:0]      uart_irq_o,
   output logic                 uart2_dma_o,
   output logic                 ir_irq_o,
   output logic                 ir_dma_o,
   input  wire logic [3:0]      gpio_pin_i,
   output logic      [3:0]      gpio_pin_o,
   output logic      [3:0]      gpio_pin_oe_o,
   input  wire logic [3:0]      gpio_out_i,
   input  wire logic [3:0]      gpio_oe_i,
   output logic      [3:0]      gpio_in_o,
   input  wire logic            port2_request_to_send_n_i,
   input  wire logic            port2_data_terminal_ready_n_i,
   output logic                 port2_data_set_ready_n_o,
   output logic                 port2_clear_to_send_n_o
);
   // ==============================================================
   // Storage
   logic [7:0]       cp_lo_reg;
   logic [7:0]       cp_hi_reg;
   logic             cp_strap_reg;
   logic [7:0]       index_reg;
   logic [7:0]       alt_reg;
   logic [3:0][7:0]  ser_base_reg;
   logic [7:0]       ir_base_reg;
   logic [7:0]       rt_base_reg;
   logic             strap_s1_reg;
   logic             strap_s2_reg;
   logic [1:0]       settle_reg;
   logic [10:0]      cp_addr;
   logic             cp_ok;
   logic             hit_idx;
   logic             hit_dat;
   logic             dat_wr;
   logic [3:0]       ser_ok;
   logic [3:0]       ser_hit;
   logic             ir_ok;
   logic             ir_hit;
   logic [7:0]       rd_val;

   // ==============================================================
   // Strap capture: two flops, then held once settled
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         strap_s1_reg <= 1'b0;
         strap_s2_reg <= 1'b0;
         settle_reg   <= 2'h0;
      end else begin
         strap_s1_reg <= config_port_strap_i;
         strap_s2_reg <= strap_s1_reg;
         if (settle_reg != cfgpm_pkg::STRAP_DONE)
            settle_reg <= 2'(settle_reg + 2'h1);
      end
   end

   // ==============================================================
   // Config port decode
   assign cp_addr = {cp_hi_reg[2:0], cp_lo_reg};
   // Strap locations sit below the relocation window, so they are
   // accepted only until software relocates the port
   assign cp_ok = (settle_reg == cfgpm_pkg::STRAP_DONE) &&
                  (cp_hi_reg[7:3] == 5'h00) && !cp_lo_reg[0] &&
                  (cp_strap_reg || (cp_addr >= cfgpm_pkg::CP_MIN &&
                   cp_addr <= cfgpm_pkg::CP_MAX));
   assign hit_idx = io_req_i && cfg_state_i && cp_ok &&
                    io_addr_i == {5'h00, cp_addr};
   assign hit_dat = io_req_i && cfg_state_i && cp_ok &&
                    io_addr_i == {5'h00,
                    11'(cp_addr + cfgpm_pkg::CP_DATA_OFS)};
   assign dat_wr  = hit_dat && io_write_i;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cp_lo_reg    <= 8'h00;
         cp_hi_reg    <= 8'h00;
         cp_strap_reg <= 1'b0;
      end else if (settle_reg == 2'h2) begin
         {cp_hi_reg, cp_lo_reg} <= {5'h00, strap_s2_reg ?
            cfgpm_pkg::CP_STRAP1 : cfgpm_pkg::CP_STRAP0};
         cp_strap_reg <= 1'b1;
      end else if (dat_wr && index_reg == cfgpm_pkg::IDX_CP_LO) begin
         cp_lo_reg    <= io_wdata_i;
         cp_strap_reg <= 1'b0;
      end else if (dat_wr && index_reg == cfgpm_pkg::IDX_CP_HI) begin
         cp_hi_reg    <= io_wdata_i;
         cp_strap_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i)
         index_reg <= 8'h00;
      else if (hit_idx && io_write_i)
         index_reg <= io_wdata_i;
   end

   // ==============================================================
   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (srst_i)
         alt_reg <= cfgpm_pkg::RST_ALT;
      else if (dat_wr && index_reg == cfgpm_pkg::IDX_ALT_HI)
         alt_reg <= io_wdata_i;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ir_base_reg <= cfgpm_pkg::RST_BASE;
         rt_base_reg <= cfgpm_pkg::RST_BASE;
      end else if (dat_wr) begin
         if (index_reg == cfgpm_pkg::IDX_IR_BASE)
            ir_base_reg <= io_wdata_i;
         if (index_reg == cfgpm_pkg::IDX_RT_BASE)
            rt_base_reg <= io_wdata_i;
      end
   end
   assign runtime_base_o = rt_base_reg;

   // Reserved indexes are read-only constants; writes are dropped
   always_comb begin
      rd_val = 8'h00;
      for (int i = 0; i < cfgpm_pkg::NUART; i++)
         if (index_reg == cfgpm_pkg::IDX_SER[i])
            rd_val = ser_base_reg[i];
      unique case (index_reg)
         cfgpm_pkg::IDX_CP_LO:   rd_val = cp_lo_reg;
         cfgpm_pkg::IDX_CP_HI:   rd_val = cp_hi_reg;
         cfgpm_pkg::IDX_IR_BASE: rd_val = ir_base_reg;
         cfgpm_pkg::IDX_RT_BASE: rd_val = rt_base_reg;
         cfgpm_pkg::IDX_ALT_HI:  rd_val = alt_reg;
         cfgpm_pkg::IDX_RSV_A:   rd_val = cfgpm_pkg::RST_RSV_A;
         cfgpm_pkg::IDX_RSV_B:   rd_val = cfgpm_pkg::RST_RSV_B;
         cfgpm_pkg::IDX_RSV_C:   rd_val = cfgpm_pkg::RST_RSV_C;
         cfgpm_pkg::IDX_RSV_D:   rd_val = cfgpm_pkg::RST_RSV_D;
         cfgpm_pkg::IDX_RSV_E:   rd_val = cfgpm_pkg::RST_RSV_E;
         cfgpm_pkg::IDX_RSV_F:   rd_val = cfgpm_pkg::RST_RSV_F;
         cfgpm_pkg::IDX_RSV_G:   rd_val = cfgpm_pkg::RST_RSV_G;
         default:                ;
      endcase
   end

   // ==============================================================
   // Logical device decode
   genvar g;
   generate
      for (g = 0; g < cfgpm_pkg::NUART; g++) begin : g_ser
         always_ff @(posedge clk_i) begin
            if (srst_i)
               ser_base_reg[g] <= cfgpm_pkg::RST_BASE;
            else if (dat_wr && index_reg == cfgpm_pkg::IDX_SER[g])
               ser_base_reg[g] <= io_wdata_i;
         end
         assign ser_ok[g] = ldev_active_i[g] &&
            {ser_base_reg[g], 3'h0} >= cfgpm_pkg::SER_MIN &&
            {ser_base_reg[g], 3'h0} <= cfgpm_pkg::SER_MAX;
         assign ser_hit[g] = io_req_i && ser_ok[g] &&
            io_addr_i[15:3] == {5'h00, ser_base_reg[g]};
      end
   endgenerate

   // Range top is the full 11-bit span, so only the floor matters
   assign ir_ok  = ldev_active_i[cfgpm_pkg::DEV_IR] &&
                   {ir_base_reg, 3'h0} >= cfgpm_pkg::IR_MIN;
   assign ir_hit = io_req_i && ir_ok &&
                   io_addr_i[15:3] == {5'h00, ir_base_reg};

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         io_claim_o   <= 1'b0;
         io_rdata_o   <= 8'h00;
         dev_cs_o     <= 5'h00;
         dev_offset_o <= 3'h0;
         dev_write_o  <= 1'b0;
         dev_wdata_o  <= 8'h00;
      end else begin
         io_claim_o   <= hit_idx || hit_dat || |ser_hit || ir_hit;
         io_rdata_o   <= hit_idx ? index_reg : hit_dat ? rd_val : 8'h00;
         dev_cs_o     <= {ir_hit, ser_hit};
         dev_offset_o <= io_addr_i[2:0];
         dev_write_o  <= io_write_i;
         dev_wdata_o  <= io_wdata_i;
      end
   end

   // ==============================================================
   // Interrupt and DMA gating
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         uart_irq_o  <= 4'h0;
         uart2_dma_o <= 1'b0;
         ir_irq_o    <= 1'b0;
         ir_dma_o    <= 1'b0;
      end else begin
         for (int i = 0; i < cfgpm_pkg::NUART; i++)
            uart_irq_o[i] <= uart_irq_raw_i[i] && ser_ok[i] &&
               uart_modem_control_reg_i[i][cfgpm_pkg::MODEM_AUX_B];
         uart2_dma_o <= uart2_dma_req_i && uart2_dma_en_i &&
                        ser_ok[1];
         ir_irq_o    <= ir_irq_raw_i && ir_irq_en_i && ir_ok;
         ir_dma_o    <= ir_dma_req_i && ir_dma_en_i && ir_ok;
      end
   end

   // ==============================================================
   // Pin multiplexer
   cfgpm_mux_if mux_if ();
   assign mux_if.alt_sel = alt_reg;
   assign mux_if.rts_n   = port2_request_to_send_n_i;
   assign mux_if.dtr_n   = port2_data_terminal_ready_n_i;
   assign port2_data_set_ready_n_o = mux_if.dsr_n;
   assign port2_clear_to_send_n_o  = mux_if.cts_n;

   cfgpm_pinmux u_pinmux (
      .clk_i      (clk_i),
      .srst_i     (srst_i),
      .mux        (mux_if.mux),
      .pin_i      (gpio_pin_i),
      .gpio_out_i (gpio_out_i),
      .gpio_oe_i  (gpio_oe_i),
      .pin_o      (gpio_pin_o),
      .pin_oe_o   (gpio_pin_oe_o),
      .gpio_in_o  (gpio_in_o)
   );

   // ==============================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_alt_reset_zero: assert property ($fell(srst_i) |->
      alt_reg == cfgpm_pkg::RST_ALT && uart_irq_o == 4'h0)
      else $error("alt select not zero after reset");
   a_alt_cfg_only: assert property (!cfg_state_i |=>
      $stable(alt_reg))
      else $error("alt select changed outside config state");
   a_alt_readback: assert property (hit_dat && !io_write_i &&
      index_reg == cfgpm_pkg::IDX_ALT_HI |=> io_claim_o &&
      io_rdata_o == alt_reg)
      else $error("alt select read-back mismatch");
   a_rsv_f_value: assert property (hit_dat && !io_write_i &&
      index_reg == cfgpm_pkg::IDX_RSV_F |=> io_rdata_o == 8'h8c)
      else $error("reserved register value wrong");
   a_strap_port: assert property ($rose(cp_strap_reg) |->
      cp_addr == (strap_s2_reg ? 11'h04e : 11'h02e) ##1
      (cp_addr == $past(cp_addr) || !cp_strap_reg))
      else $error("config port not at strap address");
   a_ser_decode: assert property (ser_hit[0] |=> dev_cs_o[0] &&
      io_claim_o && dev_offset_o == $past(io_addr_i[2:0]))
      else $error("serial port 1 cycle not claimed");
   a_ser_invalid: assert property (io_req_i &&
      ser_base_reg[1] < 8'h20 |=> !dev_cs_o[1])
      else $error("invalid serial base claimed");
   a_ir_decode: assert property (ir_hit |=> dev_cs_o[4])
      else $error("infrared cycle not claimed");
   a_irq_aux_low: assert property (!uart_modem_control_reg_i[2][2] |=>
      !uart_irq_o[2])
      else $error("port 3 interrupt passed with aux low");
   a_dma_uart2: assert property (!uart2_dma_en_i |=>
      !uart2_dma_o)
      else $error("uart2 dma passed while disabled");
   a_ir_disable: assert property (!ir_irq_en_i || !ir_ok |=>
      !ir_irq_o)
      else $error("infrared interrupt passed while disabled");

   c_alt_write: cover property (dat_wr &&
      index_reg == cfgpm_pkg::IDX_ALT_HI ##1 alt_reg == 8'h55);
   c_relocate: cover property ($fell(cp_strap_reg));
   c_ser_cycle: cover property (|dev_cs_o[3:0] && dev_write_o);
endmodule
`default_nettype wire

// [pkg/cfgpm_pkg.sv]
// Constants of the configuration-space block: register indexes,
// power-up values, address windows and field layouts.
// Assumes an 8-bit configuration data path and 16-bit host I/O space.
package cfgpm_pkg;
   // ==============================================================
   // Register indexes
   localparam logic [7:0] IDX_CP_LO   = 8'h12;
   localparam logic [7:0] IDX_CP_HI   = 8'h13;
   localparam logic [7:0] IDX_IR_BASE = 8'h2b;
   localparam logic [7:0] IDX_RT_BASE = 8'h30;
   localparam logic [7:0] IDX_ALT_HI  = 8'h4d;
   localparam logic [7:0] IDX_RSV_A   = 8'h4e;
   localparam logic [7:0] IDX_RSV_B   = 8'h4f;
   localparam logic [7:0] IDX_RSV_C   = 8'h50;
   localparam logic [7:0] IDX_RSV_D   = 8'h51;
   localparam logic [7:0] IDX_RSV_E   = 8'h52;
   localparam logic [7:0] IDX_RSV_F   = 8'h53;
   localparam logic [7:0] IDX_RSV_G   = 8'h54;
   // Serial ports 1..4, element 0 is port 1
   localparam logic [3:0][7:0] IDX_SER = {8'h1c, 8'h1b, 8'h25, 8'h24};
   // ==============================================================
   // Power-up values
   localparam logic [7:0] RST_ALT   = 8'h00;
   localparam logic [7:0] RST_RSV_A = 8'h00;
   localparam logic [7:0] RST_RSV_B = 8'h01;
   localparam logic [7:0] RST_RSV_C = 8'h00;
   localparam logic [7:0] RST_RSV_D = 8'h01;
   localparam logic [7:0] RST_RSV_E = 8'h00;
   localparam logic [7:0] RST_RSV_F = 8'h8c;
   // Undefined in hardware; this value is arbitrary
   localparam logic [7:0] RST_RSV_G = 8'h00;
   // Base registers power up invalid, so nothing is decoded
   localparam logic [7:0] RST_BASE  = 8'h00;
   // ==============================================================
   // Address windows (11-bit I/O addresses)
   localparam int          ADDR_W      = 11;
   localparam logic [10:0] CP_STRAP0   = 11'h02e;
   localparam logic [10:0] CP_STRAP1   = 11'h04e;
   localparam logic [10:0] CP_MIN      = 11'h100;
   localparam logic [10:0] CP_MAX      = 11'h7fe;
   localparam logic [10:0] CP_DATA_OFS = 11'h001;
   localparam logic [10:0] SER_MIN     = 11'h100;
   localparam logic [10:0] SER_MAX     = 11'h3f8;
   localparam logic [10:0] IR_MIN      = 11'h100;
   localparam logic [10:0] IR_MAX      = 11'h7f8;
   // ==============================================================
   // Fields
   localparam int         NUART      = 4;
   localparam int         NPIN       = 4;
   localparam int         ALT_FLD_W  = 2;
   localparam logic [1:0] ALT_GPIO   = 2'b00;
   localparam logic [1:0] ALT_UART   = 2'b01;
   localparam int         MODEM_AUX_B = 2;
   localparam int         DEV_IR     = 4;
   localparam logic [1:0] STRAP_DONE = 2'h3;
endpackage

// [pkg/cfgpm_mux_if.sv]
// Carrier between the register bank and the pin multiplexer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface cfgpm_mux_if;
   logic [7:0] alt_sel;
   logic       rts_n;
   logic       dtr_n;
   logic       dsr_n;
   logic       cts_n;
   modport regs (output alt_sel, output rts_n, output dtr_n,
                 input dsr_n, input cts_n);
   modport mux  (input alt_sel, input rts_n, input dtr_n,
                 output dsr_n, output cts_n);
endinterface
`default_nettype wire

// [verilog/cfgpm_pinmux.sv]
// Pin multiplexer for the high GPIO group (pins 54..57).
// Assumes pin inputs are asynchronous and GPIO controls are on clk_i.
`timescale 1ns/10ps
`default_nettype none
module cfgpm_pinmux (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   cfgpm_mux_if.mux        mux,
   input  wire logic [3:0] pin_i,
   input  wire logic [3:0] gpio_out_i,
   input  wire logic [3:0] gpio_oe_i,
   output logic      [3:0] pin_o,
   output logic      [3:0] pin_oe_o,
   output logic      [3:0] gpio_in_o
);
   // ==============================================================
   // Per-pin decode and output path
   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [3:0] alt_on;
   logic [3:0] alt_val;

   // Pins 55 and 57 carry the UART outputs; 54 and 56 are inputs
   assign alt_val = {mux.dtr_n, 1'b1, mux.rts_n, 1'b1};

   genvar g;
   generate
      for (g = 0; g < cfgpm_pkg::NPIN; g++) begin : g_pin
         // Reserved codes fall back to plain GPIO
         assign alt_on[g] = mux.alt_sel[g*cfgpm_pkg::ALT_FLD_W +:
                            cfgpm_pkg::ALT_FLD_W] == cfgpm_pkg::ALT_UART;
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               s1_reg[g]   <= 1'b0;
               s2_reg[g]   <= 1'b0;
               pin_o[g]    <= 1'b0;
               pin_oe_o[g] <= 1'b0;
            end else begin
               s1_reg[g]   <= pin_i[g];
               s2_reg[g]   <= s1_reg[g];
               pin_o[g]    <= alt_on[g] ? alt_val[g] : gpio_out_i[g];
               // Direction stays with software in either function
               pin_oe_o[g] <= gpio_oe_i[g];
            end
         end
      end
   endgenerate

   assign gpio_in_o = s2_reg;

   // Idle-high modem inputs while the pin is plain GPIO
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mux.dsr_n <= 1'b1;
         mux.cts_n <= 1'b1;
      end else begin
         mux.dsr_n <= alt_on[0] ? s2_reg[0] : 1'b1;
         mux.cts_n <= alt_on[2] ? s2_reg[2] : 1'b1;
      end
   end

   a_rsv_is_gpio: assert property (@(posedge clk_i)
      disable iff (srst_i)
      mux.alt_sel[7] |=> pin_o[3] == $past(gpio_out_i[3]))
      else $error("reserved code left pin 57 off GPIO");
endmodule
`default_nettype wire

// [verif/cfgpm_host.sv]
// Host I/O master model for the configuration-space block.
// Assumes every task is entered at a falling edge of clk_i.
`timescale 1ns/10ps
`default_nettype none
module cfgpm_host (
   input  wire logic        clk_i,
   input  wire logic        io_claim_i,
   input  wire logic [7:0]  io_rdata_i,
   output logic             io_req_o,
   output logic             io_write_o,
   output logic      [15:0] io_addr_o,
   output logic      [7:0]  io_wdata_o
);
   logic [15:0] cp;
   initial begin
      cp = 16'h002e;
      {io_req_o, io_write_o, io_addr_o, io_wdata_o} = '0;
   end
   // ==============================================================
   // Bus cycles
   // Request is left raised so cycles can run back to back
   task automatic cyc(input logic wr, input logic [15:0] a,
         input logic [7:0] d, output logic c, output logic [7:0] r);
      io_req_o = 1'b1;
      io_write_o = wr;
      io_addr_o = a;
      io_wdata_o = d;
      @(negedge clk_i);
      c = io_claim_i;
      r = io_rdata_i;
   endtask
   // Idle lines carry junk so stale values are never trusted
   task automatic idle();
      io_req_o = 1'b0;
      io_addr_o = ~io_addr_o;
      io_wdata_o = ~io_wdata_o;
      @(negedge clk_i);
   endtask
   task automatic cfg(input logic wr, input logic [7:0] idx,
         input logic [7:0] d, output logic c, output logic [7:0] r);
      logic c0;
      cyc(1'b1, cp, idx, c0, r);
      cyc(wr, cp + 16'h0001, d, c, r);
      c = c & c0;
   endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the configuration-space register bank.
// Assumes the host model owns the I/O port; all else is driven here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ==============================================================
   // Signals
   logic        clk, srst, cfg_st, strap, req, wr, claim, c, dw;
   logic        u2dr, u2de, irr, ire, idr, ide, rts, dtr, dsr, cts;
   logic        u2d_o, iri_o, ird_o;
   logic [15:0] addr;
   logic [7:0]  wd, rd, dwd, rtb, v, av, b, r;
   logic [4:0]  act, cs;
   logic [3:0]  uirq, uirq_o, pin, pin_o, oe_o, gout, goe, gin, u, e, m;
   logic [3:0][7:0] mctl;
   logic [2:0]  ofs, dofs;
   logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
                           8'h8c, 8'h00};
   logic [7:0]  bl [5] = '{8'h1f, 8'h20, 8'h7f, 8'h80, 8'hff};
   logic [7:0]  ix [5] = '{8'h24, 8'h25, 8'h1b, 8'h1c, 8'h2b};
   int          n_errors, samples_checked, seed, cyc_n;

   cfgpm_top dut_u (.clk_i(clk), .srst_i(srst), .cfg_state_i(cfg_st),
      .config_port_strap_i(strap), .io_req_i(req), .io_write_i(wr),
      .io_addr_i(addr), .io_wdata_i(wd), .io_claim_o(claim),
      .io_rdata_o(rd), .dev_cs_o(cs), .dev_offset_o(dofs),
      .dev_write_o(dw), .dev_wdata_o(dwd), .runtime_base_o(rtb),
      .ldev_active_i(act), .uart_irq_raw_i(uirq),
      .uart_modem_control_reg_i(mctl),
      .uart2_dma_req_i(u2dr), .uart2_dma_en_i(u2de),
      .ir_irq_raw_i(irr), .ir_irq_en_i(ire), .ir_dma_req_i(idr),
      .ir_dma_en_i(ide), .uart_irq_o(uirq_o), .uart2_dma_o(u2d_o),
      .ir_irq_o(iri_o), .ir_dma_o(ird_o), .gpio_pin_i(pin),
      .gpio_pin_o(pin_o), .gpio_pin_oe_o(oe_o), .gpio_out_i(gout),
      .gpio_oe_i(goe), .gpio_in_o(gin),
      .port2_request_to_send_n_i(rts),
      .port2_data_terminal_ready_n_i(dtr),
      .port2_data_set_ready_n_o(dsr), .port2_clear_to_send_n_o(cts));
   cfgpm_host host_u (.clk_i(clk), .io_claim_i(claim), .io_rdata_i(rd),
      .io_req_o(req), .io_write_o(wr), .io_addr_o(addr),
      .io_wdata_o(wd));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Whole run needs a few hundred cycles; generous ceiling
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n >= 20000) begin
         n_errors++;
         stop_test();
      end
   end
   // ==============================================================
   // Helpers
   task automatic chk(input string nm, input logic [7:0] x,
         input logic [7:0] g);
      samples_checked++;
      if (g !== x) begin
         $display("Error %s expected %h seen %h", nm, x, g);
         n_errors++;
      end
   endtask
   function automatic logic base_ok(input int d, input logic [7:0] b);
      return b >= 8'h20 && (d == 4 || b <= 8'h7f);
   endfunction
   function automatic logic [3:0] pin_exp(input logic [3:0] u,
         input logic [3:0] o, input logic hi, input logic lo);
      return (o & ~u) | (u & {hi, 1'b0, lo, 1'b0});
   endfunction
   task automatic rst();
      srst = 1'b1;
      host_u.idle();
      repeat (15) @(negedge clk);
      srst = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==============================================================
   // Tests
   initial begin
      seed = 29386;
      {n_errors, samples_checked, cyc_n} = '0;
      {cfg_st, strap, srst, u2dr, u2de, irr, ire, idr, ide} = 9'h140;
      {rts, dtr, act, uirq, pin, gout, goe, mctl} = 55'h3 << 53;
      rst();
      for (int i = 0; i < 8; i++) begin
         host_u.cfg(1'b0, 8'h4d + 8'(i), 8'h00, c, r);
         chk("cfg_claim", 8'h01, 8'(c));
         chk("power_up", rv[i], r);
         if (i > 0) begin
            host_u.cfg(1'b1, 8'h4d + 8'(i), 8'hff, c, r);
            host_u.cfg(1'b0, 8'h4d + 8'(i), 8'h00, c, r);
            chk("reserved", rv[i], r);
         end
      end
      host_u.cfg(1'b1, 8'h30, 8'ha6, c, r);
      chk("rt_base", 8'ha6, rtb);
      cfg_st = 1'b0;
      host_u.cfg(1'b1, 8'h4d, 8'hff, c, r);
      chk("no_cfg_state", 8'h00, 8'(c));
      cfg_st = 1'b1;
      host_u.cfg(1'b0, 8'h4d, 8'h00, c, r);
      chk("no_cfg_write", 8'h00, r);
      chk("rt_kept", 8'ha6, rtb);
      $display("test reset done");
      for (int k = 0; k < 12; k++) begin
         av = (k == 0) ? 8'h55 : (k == 1) ? 8'hae : 8'($random(seed));
         for (int i = 0; i < 4; i++) u[i] = (av[2*i+:2] == 2'b01);
         {pin, gout, rts, dtr, goe} = 14'($random(seed));
         goe = (goe & ~u) | (u & 4'b1010);
         host_u.cfg(1'b1, 8'h4d, av, c, r);
         host_u.idle();
         repeat (4) @(negedge clk);
         host_u.cfg(1'b0, 8'h4d, 8'h00, c, r);
         host_u.idle();
         chk("alt_sel", av, r);
         e = pin_exp(u, gout, dtr, rts);
         m = ~u | 4'b1010;
         chk("pin_out", 8'(e & m), 8'(pin_o & m));
         chk("pin_oe", 8'(goe), 8'(oe_o));
         chk("gpio_in", 8'(pin & ~u), 8'(gin & ~u));
         chk("dsr_cts", {6'h0, u[2] ? pin[2] : 1'b1, u[0] ? pin[0] : 1'b1},
             {6'h0, cts, dsr});
      end
      $display("test pin_mux done");
      for (int d = 0; d < 5; d++) begin
         for (int k = 0; k < 6; k++) begin
            b = (k == 5) ? 8'($random(seed)) : bl[k];
            // Keep clear of the config port and of placed devices
            if (b < 8'h10 || b[7:5] == 3'b010 || b[7:4] == 4'h6)
               b = b ^ 8'h80;
            {act, ofs, v} = 16'($random(seed));
            host_u.cfg(1'b1, ix[d], b, c, r);
            host_u.cyc(v[0], {5'h00, b, ofs}, v, c, r);
            e[0] = act[d] && base_ok(d, b);
            chk("base_claim", 8'(e[0]), 8'(c));
            chk("dev_cs", e[0] ? 8'(5'h1 << d) : 8'h00, 8'(cs));
            if (e[0]) begin
               chk("dev_ofs", {4'h0, v[0], ofs}, {4'h0, dw, dofs});
               chk("dev_wdata", v, dwd);
            end
         end
         host_u.cfg(1'b1, ix[d], 8'h40 + 8'(8 * d), c, r);
      end
      host_u.idle();
      $display("test base_decode done");
      repeat (24) begin
         {act, uirq, u2dr, u2de, irr, ire, idr, ide} = 15'($random(seed));
         mctl = $random(seed);
         @(negedge clk);
         for (int i = 0; i < 4; i++) e[i] = uirq[i] & act[i] & mctl[i][2];
         chk("uart_irq", 8'(e), 8'(uirq_o));
         chk("dma_ir", {5'h0, u2dr & u2de & act[1], irr & ire & act[4],
             idr & ide & act[4]}, {5'h0, u2d_o, iri_o, ird_o});
      end
      $display("test gating done");
      host_u.cfg(1'b0, 8'h12, 8'h00, c, r);
      b = r;
      chk("cp_low", 8'h2e, r);
      host_u.cfg(1'b1, 8'h13, 8'h02, c, r);
      host_u.cp = {5'h00, 3'h2, b};
      // Clear of every placed serial and infrared window
      host_u.cfg(1'b1, 8'h12, 8'h70, c, r);
      host_u.cp = 16'h0270;
      host_u.cfg(1'b0, 8'h4d, 8'h00, c, r);
      chk("reloc_claim", 8'h01, 8'(c));
      chk("reloc_read", av, r);
      host_u.cyc(1'b0, 16'h0270, 8'h00, c, r);
      chk("index_read", 8'h4d, r);
      host_u.cyc(1'b0, 16'h002e, 8'h00, c, r);
      chk("old_port", 8'h00, 8'(c));
      $display("test relocate done");
      strap = 1'b1;
      rst();
      host_u.cp = 16'h004e;
      host_u.cfg(1'b0, 8'h4d, 8'h00, c, r);
      chk("strap_claim", 8'h01, 8'(c));
      chk("alt_reset", 8'h00, r);
      host_u.cyc(1'b1, 16'h002e, 8'h4d, c, r);
      chk("strap_other", 8'h00, 8'(c));
      host_u.idle();
      $display("test strap done");
      stop_test();
   end
endmodule
`default_nettype wire
